// ==== spi_echo_slave.sv ====
`timescale 1ns/100ps
// ==========
// Loopback slave
module spi_echo_slave (
   // Bus
   input  wire       sck,
   input  wire       mosi,
   input  wire [2:0] sel_n,
   output wire       miso
);
   reg  last_reg = 1'b0;
   wire on = ~&sel_n;
   always @(mosi) if (on) last_reg = mosi;
   // Released line shows the inverse of the last bit seen while selected
   assign miso = on ? mosi : ~last_reg;
endmodule // spi_echo_slave

// ==== spi_master_properties.sv ====
`timescale 1ns/100ps
// ==========
// Port checker
module spi_master_checker (
   // Clock, commands
   input wire        clock,
   input wire        resetn,
   input wire        start_cmd,
   input wire        stop_cmd,
   input wire        disable_cmd,
   input wire        select_write,
   input wire [2:0]  select_mask,
   // Status, pins
   input wire [19:0] config_snapshot,
   input wire        rx_valid,
   input wire        busy,
   input wire        done_irq,
   input wire        enabled,
   input wire        sck,
   input wire        master_select_line_0,
   input wire        master_select_line_1,
   input wire        master_select_line_2
);
   wire [2:0] sel = {master_select_line_2, master_select_line_1, master_select_line_0};
   wire [1:0] cnt = config_snapshot[1:0];
   wire [2:0] okm = (cnt == 2'h0) ? 3'h1 : (cnt == 2'h1) ? 3'h3 : 3'h7;
   wire       aut = config_snapshot[12];
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   a_off_deselects: assert property (!enabled |-> sel == 3'h7)
      else $error("select active while off");
   a_start_busy: assert property (start_cmd && enabled && !busy && !rx_valid && !disable_cmd
      |=> busy) else $error("start not taken");
   a_irq_gated: assert property (done_irq |-> config_snapshot[11] && $past(busy))
      else $error("stray done pulse");
   a_word_ready: assert property (done_irq |=> rx_valid)
      else $error("no word after done");
   a_auto_idle: assert property (enabled && aut && !busy && !$past(busy) |-> sel == 3'h7)
      else $error("auto select while idle");
   a_manual_mask: assert property (enabled && !aut && select_write && !stop_cmd
      |=> sel == ~($past(select_mask) & okm)) else $error("mask wrong");
   a_stop_clears: assert property (enabled && !aut && stop_cmd |=> sel == 3'h7)
      else $error("stop left select");
   a_idle_level: assert property (enabled && !busy && !$past(busy) && $stable(config_snapshot)
      |-> sck == config_snapshot[3]) else $error("idle clock level");
endmodule // spi_master_checker
bind spi_master_transfer_engine spi_master_checker chk (.*);

// ==== spi_master_regs.vh ====
`ifndef SPI_MASTER_REGS_VH
`define SPI_MASTER_REGS_VH
// ==========================================
// Configuration snapshot field layout
`define CFG_WIDTH        20
`define CFG_COUNT_LO     0
`define CFG_COUNT_HI     1
`define CFG_LSB_FIRST    2
`define CFG_POLARITY     3
`define CFG_PHASE        4
`define CFG_DIV_LO       5
`define CFG_DIV_HI       10
`define CFG_IRQ_EN       11
`define CFG_AUTO_SEL     12
`define CFG_READ_DELAY   13
`define CFG_ENABLE       14
`define CFG_CONT         15
`define CFG_MASK_LO      16
`define CFG_MASK_HI      18
`define CFG_SPARE        19
// ==========================================
// Reset values
`define CFG_RESET        20'h00000
`define FIFO_DEPTH_DEF   8
`endif

// ==== spi_master_transfer_engine.v ====
`timescale 1ns/100ps
`include "spi_master_regs.vh"

// ==========================================
// Receive word FIFO
module spi_rx_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = `FIFO_DEPTH_DEF,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             clock,
   input  wire             resetn,
   input  wire             flush,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output reg  [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr_reg;
   reg [AW:0]      rd_ptr_reg;
   wire [AW:0]     fill;
   wire            push;
   wire            pop;

   assign fill      = wr_ptr_reg - rd_ptr_reg;
   assign in_ready  = (fill < DEPTH);
   assign out_valid = (fill != {(AW+1){1'b0}});
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always @(posedge clock) begin
      if (push)
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
   end

   always @* begin
      out_data = mem[rd_ptr_reg[AW-1:0]];
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else if (flush) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
      end
   end
endmodule // spi_rx_fifo

// ==========================================
// SPI master transfer engine
module spi_master_transfer_engine #(
   parameter FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
   // Clock and reset
   input  wire        clock,
   input  wire        resetn,
   // Configuration command
   input  wire        config_write,
   input  wire [1:0]  select_line_count,
   input  wire        low_bit_first,
   input  wire        clock_polarity,
   input  wire        clock_phase,
   input  wire [5:0]  sck_divisor,
   input  wire        done_irq_enable,
   input  wire        auto_select_enable,
   // Snapshot and restore
   output wire [19:0] config_snapshot,
   input  wire        config_restore,
   input  wire [19:0] config_restore_data,
   // Commands
   input  wire        select_write,
   input  wire [2:0]  select_mask,
   input  wire        stop_cmd,
   input  wire        disable_cmd,
   input  wire        start_cmd,
   input  wire [4:0]  length_code,
   input  wire [31:0] tx_word,
   input  wire        continuous_write,
   input  wire        continuous_enable,
   input  wire        read_edge_write,
   input  wire        read_edge_delay,
   // Receive side
   input  wire        rx_read,
   output wire [31:0] rx_word,
   output wire [15:0] rx_half,
   output wire [7:0]  rx_byte,
   output wire        rx_valid,
   // Status
   output wire        busy,
   output reg         done_irq,
   output wire        enabled,
   // SPI pins
   output reg         sck,
   output wire        mosi,
   input  wire        miso,
   output wire        master_select_line_0,
   output wire        master_select_line_1,
   output wire        master_select_line_2
);
   localparam ST_IDLE = 2'h0;
   localparam ST_LEAD = 2'h1;
   localparam ST_TRAIL = 2'h2;

   reg [19:0] cfg_reg;
   reg [1:0]  state_reg;
   reg [5:0]  div_cnt_reg;
   reg [4:0]  len_reg;
   reg [4:0]  bit_cnt_reg;
   reg [31:0] tx_reg;
   reg [31:0] rx_sh_reg;
   reg        mosi_reg;
   reg        last_one_reg;
   reg        kick_reg;
   reg        fifo_push_q;
   wire       tick;
   wire       fifo_ready;
   wire       can_start;
   wire       lead_sample;
   wire       sample_now;
   wire [2:0] mask_ok;
   wire [31:0] rx_aligned;
   wire       cont;

   assign cont    = cfg_reg[`CFG_CONT];
   assign enabled = cfg_reg[`CFG_ENABLE];
   assign config_snapshot = cfg_reg;

   // ==========================================
   // Configuration state
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cfg_reg <= `CFG_RESET;
      end else if (config_restore) begin
         cfg_reg <= config_restore_data;
      end else begin
         if (config_write) begin
            cfg_reg[`CFG_COUNT_HI:`CFG_COUNT_LO] <= select_line_count;
            cfg_reg[`CFG_LSB_FIRST]              <= low_bit_first;
            cfg_reg[`CFG_POLARITY]               <= clock_polarity;
            cfg_reg[`CFG_PHASE]                  <= clock_phase;
            cfg_reg[`CFG_DIV_HI:`CFG_DIV_LO]     <= sck_divisor;
            cfg_reg[`CFG_IRQ_EN]                 <= done_irq_enable;
            cfg_reg[`CFG_AUTO_SEL]               <= auto_select_enable;
            cfg_reg[`CFG_ENABLE]                 <= 1'b1;
         end
         if (select_write)
            cfg_reg[`CFG_MASK_HI:`CFG_MASK_LO] <= select_mask & mask_ok;
         if (stop_cmd)
            cfg_reg[`CFG_MASK_HI:`CFG_MASK_LO] <= 3'h0;
         if (read_edge_write)
            cfg_reg[`CFG_READ_DELAY] <= read_edge_delay;
         if (continuous_write)
            cfg_reg[`CFG_CONT] <= continuous_enable;
         if (disable_cmd) begin
            cfg_reg[`CFG_ENABLE] <= 1'b0;
            cfg_reg[`CFG_CONT]   <= 1'b0;
         end
      end
   end

   // Count of lines limits the mask
   assign mask_ok = (cfg_reg[`CFG_COUNT_HI:`CFG_COUNT_LO] == 2'h0) ? 3'h1 :
                    (cfg_reg[`CFG_COUNT_HI:`CFG_COUNT_LO] == 2'h1) ? 3'h3 : 3'h7;

   // ==========================================
   // Select lines
   wire [2:0] sel_active;
   assign sel_active = (cfg_reg[`CFG_AUTO_SEL] && !busy) ? 3'h0 :
                       cfg_reg[`CFG_MASK_HI:`CFG_MASK_LO] & mask_ok;
   // Active low select lines, high when disabled
   assign master_select_line_0 = !(enabled && sel_active[0]);
   assign master_select_line_1 = !(enabled && sel_active[1]);
   assign master_select_line_2 = !(enabled && sel_active[2]);

   // ==========================================
   // Half-period enable divider
   assign tick = (cfg_reg[`CFG_DIV_HI:`CFG_DIV_LO] == 6'h00) ||
                 (div_cnt_reg == cfg_reg[`CFG_DIV_HI:`CFG_DIV_LO] - 6'h01);

   always @(posedge clock or negedge resetn) begin
      if (!resetn)
         div_cnt_reg <= 6'h00;
      else if (state_reg == ST_IDLE || tick)
         div_cnt_reg <= 6'h00;
      else
         div_cnt_reg <= div_cnt_reg + 6'h01;
   end

   // ==========================================
   // Transfer sequencer
   // Busy covers the push cycle so a falling busy means the word is readable
   assign busy       = (state_reg != ST_IDLE) || kick_reg || fifo_push_q;
   // Leading-edge sample for phase 0, trailing for phase 1
   assign lead_sample = !cfg_reg[`CFG_PHASE];
   assign sample_now = tick && !cfg_reg[`CFG_READ_DELAY] &&
                       ((state_reg == ST_LEAD) == lead_sample);
   assign can_start  = enabled && fifo_ready && !fifo_push_q;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg      <= ST_IDLE;
         len_reg        <= 5'h00;
         bit_cnt_reg    <= 5'h00;
         tx_reg         <= 32'h00000000;
         rx_sh_reg      <= 32'h00000000;
         mosi_reg       <= 1'b0;
         sck            <= 1'b0;
         done_irq       <= 1'b0;
         last_one_reg   <= 1'b0;
         kick_reg       <= 1'b0;
      end else begin
         done_irq <= 1'b0;
         // Enabling continuous mode kicks off the first transfer
         if (continuous_write && continuous_enable && !cont)
            kick_reg <= 1'b1;
         if (continuous_write && !continuous_enable && cont)
            last_one_reg <= 1'b1;
         if (state_reg == ST_IDLE)
            sck <= cfg_reg[`CFG_POLARITY];
         case (state_reg)
            ST_IDLE: begin
               if (can_start && (start_cmd || kick_reg ||
                   ((cont || last_one_reg) && rx_read))) begin
                  state_reg   <= ST_LEAD;
                  kick_reg    <= 1'b0;
                  len_reg     <= length_code;
                  tx_reg      <= tx_word;
                  bit_cnt_reg <= 5'h00;
                  rx_sh_reg   <= 32'h00000000;
                  mosi_reg    <= low_bit_first_sel(cfg_reg[`CFG_LSB_FIRST], tx_word,
                                                   length_code);
                  if (!cont)
                     last_one_reg <= 1'b0;
               end
            end
            ST_LEAD: begin
               if (tick) begin
                  sck       <= !sck;
                  state_reg <= ST_TRAIL;
                  if (sample_now)
                     rx_sh_reg <= {rx_sh_reg[30:0], miso};
                  else if (cfg_reg[`CFG_READ_DELAY] && !lead_sample)
                     rx_sh_reg <= {rx_sh_reg[30:0], miso};
               end
            end
            ST_TRAIL: begin
               if (tick) begin
                  sck <= !sck;
                  if (sample_now || (cfg_reg[`CFG_READ_DELAY] && lead_sample))
                     rx_sh_reg <= {rx_sh_reg[30:0], miso};
                  if (bit_cnt_reg == len_reg) begin
                     state_reg <= ST_IDLE;
                     done_irq  <= cfg_reg[`CFG_IRQ_EN];
                     if (!cont)
                        last_one_reg <= 1'b0;
                  end else begin
                     state_reg   <= ST_LEAD;
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                     mosi_reg    <= tx_reg[tx_idx_next(cfg_reg[`CFG_LSB_FIRST],
                                                       bit_cnt_reg, len_reg)];
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
         if (disable_cmd) begin
            state_reg    <= ST_IDLE;
            kick_reg     <= 1'b0;
            last_one_reg <= 1'b0;
         end
      end
   end

   function automatic low_bit_first_sel;
      input        lsb;
      input [31:0] w;
      input [4:0]  n;
      begin
         low_bit_first_sel = lsb ? w[0] : w[n];
      end
   endfunction

   function automatic [4:0] tx_idx_next;
      input       lsb;
      input [4:0] cnt;
      input [4:0] n;
      begin
         tx_idx_next = lsb ? cnt + 5'h01 : n - cnt - 5'h01;
      end
   endfunction

   assign mosi = mosi_reg;

   // ==========================================
   // Receive word alignment and buffering
   genvar g;
   generate
      for (g = 0; g < 32; g = g + 1) begin : g_align
         // LSB-first arrives reversed within the N+1 bits
         assign rx_aligned[g] = (g > len_reg) ? 1'b0 :
                                cfg_reg[`CFG_LSB_FIRST] ? rx_sh_reg[len_reg - g] :
                                rx_sh_reg[g];
      end
   endgenerate

   // A full FIFO stalls any start through fifo_ready; continuous restart waits for rx_read
   spi_rx_fifo #(
      .WIDTH (32),
      .DEPTH (FIFO_DEPTH),
      .AW    (3)
   ) u_rx_fifo (
      .clock     (clock),
      .resetn    (resetn),
      .flush     (disable_cmd),
      .in_valid  (fifo_push_q),
      .in_ready  (fifo_ready),
      .in_data   (rx_aligned),
      .out_valid (rx_valid),
      .out_ready (rx_read),
      .out_data  (rx_word)
   );

   // Push one cycle after the last edge so the final sample is in
   always @(posedge clock or negedge resetn) begin
      if (!resetn)
         fifo_push_q <= 1'b0;
      else
         fifo_push_q <= state_reg == ST_TRAIL && tick && bit_cnt_reg == len_reg;
   end

   assign rx_half = rx_word[15:0];
   assign rx_byte = rx_word[7:0];
endmodule // spi_master_transfer_engine

// ==== test_spi_master_transfer_engine.sv ====
`timescale 1ns/100ps
// ==========
// Bench
module test_spi_master_transfer_engine;
   reg         clock, resetn, config_write, low_bit_first, clock_polarity, clock_phase;
   reg         done_irq_enable, auto_select_enable, config_restore, select_write, stop_cmd;
   reg         disable_cmd, start_cmd, continuous_write, continuous_enable;
   reg         read_edge_write, read_edge_delay, rx_read;
   reg  [1:0]  select_line_count;
   reg  [5:0]  sck_divisor;
   reg  [19:0] config_restore_data, snap;
   reg  [2:0]  select_mask;
   reg  [4:0]  length_code;
   reg  [31:0] tx_word, w, m;
   wire [19:0] config_snapshot;
   wire [31:0] rx_word;
   wire [15:0] rx_half;
   wire [7:0]  rx_byte;
   wire        rx_valid, busy, done_irq, enabled, sck, mosi, miso;
   wire        master_select_line_0, master_select_line_1, master_select_line_2;
   wire [2:0]  sels = {master_select_line_2, master_select_line_1, master_select_line_0};
   integer     fails = 0, compares = 0, cyc = 0, irqs = 0, starts = 0, bc, i, j, n, h, c;
   integer     lens [0:7] = '{0, 7, 15, 31, 4, 8, 23, 1};
   integer     divs [0:7] = '{0, 1, 3, 2, 1, 0, 2, 1};
   reg         busy_d = 1'b0;
   spi_master_transfer_engine uut (.*);
   spi_echo_slave echo (.sck(sck), .mosi(mosi), .sel_n(sels), .miso(miso));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // Budget far above the longest sequence
   always @(posedge clock) begin
      cyc <= cyc + 1;
      irqs <= irqs + (done_irq === 1'b1);
      busy_d <= busy;
      if (busy === 1'b1 && busy_d !== 1'b1) starts <= starts + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         end_of_test;
      end
   end
   task chk(input string what, input [31:0] exp, input [31:0] got);
      compares = compares + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task cfg(input [1:0] k, input l, p, f, input [5:0] d, input q, a);
      @(posedge clock);
      {select_line_count, low_bit_first, clock_polarity, clock_phase} <= {k, l, p, f};
      {sck_divisor, done_irq_enable, auto_select_enable, config_write} <= {d, q, a, 1'b1};
      @(posedge clock);
      config_write <= 1'b0;
   endtask
   task sel(input [2:0] k, input s);
      @(posedge clock);
      {select_mask, select_write, stop_cmd} <= {k, !s, s};
      @(posedge clock);
      {select_write, stop_cmd} <= 2'h0;
   endtask
   task go(input [4:0] k, input [31:0] d);
      @(posedge clock);
      {length_code, tx_word, start_cmd} <= {k, d, 1'b1};
      @(posedge clock);
      start_cmd <= 1'b0;
   endtask
   task idle;
      bc = 0;
      #1;
      while (busy !== 1'b0 && bc < 4000) begin
         @(posedge clock);
         #1 bc = bc + 1;
      end
   endtask
   task pop;
      @(posedge clock) rx_read <= 1'b1;
      @(posedge clock) rx_read <= 1'b0;
   endtask
   task rd(input [31:0] e);
      #1 chk("word", e, rx_word);
      chk("half", e[15:0], rx_half);
      chk("byte", e[7:0], rx_byte);
      pop;
   endtask
   task end_of_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      {config_write, low_bit_first, clock_polarity, clock_phase, done_irq_enable} = 0;
      {auto_select_enable, config_restore, select_write, stop_cmd, disable_cmd} = 0;
      {start_cmd, continuous_write, continuous_enable, read_edge_write} = 0;
      {read_edge_delay, rx_read, select_line_count, sck_divisor, select_mask} = 0;
      {config_restore_data, length_code, tx_word} = 0;
      resetn = 1'b0;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      #1 chk("sel", 3'h7, sels);
      chk("enabled", 1'h0, enabled);
      go(5'h3, 32'h5);
      #1 chk("busy", 1'h0, busy);
      for (i = 0; i < 3; i = i + 1) begin
         cfg(i[1:0], 0, 0, 0, 6'h1, 0, 0);
         sel(3'h7, 0);
         #1 chk("mask", 3'(3'h7 << (i + 1)), sels);
         sel(3'h0, 1);
         #1 chk("stop", 3'h7, sels);
      end
      // Every mode and both bit orders, short to full length
      for (i = 0; i < 8; i = i + 1) begin
         n = lens[i];
         h = (divs[i] == 0) ? 1 : divs[i];
         cfg(2'h0, i[2], i[0], i[1], divs[i], 1, 0);
         sel(3'h1, 0);
         w = 32'ha5c396f1 ^ (i * 32'h11111111);
         m = 32'hffffffff >> (31 - n);
         c = irqs;
         go(n, w);
         #1 if (!i[1]) chk("first", i[2] ? w[0] : w[n], mosi);
         idle;
         chk("length", 1, bc >= 2 * (n + 1) * h - 2 && bc <= 2 * (n + 1) * h + 2);
         rd(w & m);
         chk("irq", c + 1, irqs);
      end
      cfg(2'h0, 0, 0, 0, 6'h0, 0, 0);
      c = irqs;
      for (j = 0; j < 9; j = j + 1) begin
         go(5'h7, j);
         idle;
      end
      chk("full", 0, bc);
      chk("irq_off", c, irqs);
      for (j = 0; j < 8; j = j + 1) rd(j);
      #1 chk("empty", 1'h0, rx_valid);
      cfg(2'h0, 0, 0, 0, 6'h1, 1, 1);
      sel(3'h1, 0);
      #1 chk("auto_idle", 3'h7, sels);
      go(5'hf, 32'h1234);
      repeat (2) @(posedge clock);
      #1 chk("auto_run", 3'h6, sels);
      idle;
      @(posedge clock) #1 chk("auto_end", 3'h7, sels);
      rd(32'h1234);
      snap = config_snapshot;
      chk("snap_div", 6'h1, snap[10:5]);
      chk("snap_auto", 1'h1, snap[12]);
      cfg(2'h2, 1, 1, 1, 6'h2a, 0, 0);
      @(posedge clock) {config_restore_data, config_restore} <= {snap, 1'b1};
      @(posedge clock) config_restore <= 1'b0;
      #1 chk("restore", snap, config_snapshot);
      @(posedge clock) {read_edge_delay, read_edge_write} <= 2'h3;
      @(posedge clock) read_edge_write <= 1'b0;
      go(5'h7, 32'h3c);
      idle;
      chk("delayed", 1'h0, busy);
      chk("delayed_word", 32'h3c, rx_word);
      pop;
      c = starts;
      @(posedge clock) {length_code, continuous_enable, continuous_write} <= {5'h7, 2'h3};
      @(posedge clock) continuous_write <= 1'b0;
      repeat (2) @(posedge clock);
      idle;
      repeat (20) @(posedge clock);
      #1 chk("cont_first", c + 1, starts);
      chk("cont_ready", 1'h1, rx_valid & ~busy);
      pop;
      repeat (2) @(posedge clock);
      idle;
      chk("cont_next", c + 2, starts);
      @(posedge clock) {continuous_enable, continuous_write} <= 2'h1;
      @(posedge clock) continuous_write <= 1'b0;
      for (j = 0; j < 300; j = j + 1)
         @(posedge clock) rx_read <= rx_valid === 1'b1 && rx_read !== 1'b1;
      @(posedge clock) rx_read <= 1'b0;
      #1 chk("cont_last", c + 3, starts);
      go(5'h7, 32'h1);
      idle;
      go(5'h1f, 32'h0);
      repeat (5) @(posedge clock);
      disable_cmd <= 1'b1;
      @(posedge clock) disable_cmd <= 1'b0;
      #1 chk("dis_busy", 1'h0, busy);
      chk("dis_on", 1'h0, enabled);
      chk("dis_fifo", 1'h0, rx_valid);
      end_of_test;
   end
endmodule // test_spi_master_transfer_engine
